// *** sim/psb_ref_model.sv ***
// far side model: reference clock source and board trace back to the loop input
// assumes all of it synchronous to clk_i; the bench sets half period and returned output
`timescale 1ns/100ps
module psb_ref_model (
   input  wire logic        clk_i,         // clock
   input  wire logic        rst_i,         // reset
   input  wire logic [15:0] half_i,        // reference half period in cycles
   input  wire logic [2:0]  ret_i,         // returned output, 4..7 pick second outputs
   input  wire logic [3:0]  out_a_i,       // first outputs
   input  wire logic [3:0]  out_b_i,       // second outputs
   output logic             ref_clk_o,     // reference clock
   output logic             loop_return_o  // returned output
);
   logic [15:0] cnt_q;
   wire         wrap = cnt_q >= half_i - 16'h1;
   // ==========================================================================
   // reference toggles each half period; the bench's 150 cycle period lies outside the low and high ranges in its range test
   always_ff @(posedge clk_i) begin
      cnt_q     <= (rst_i || wrap) ? 16'h0 : cnt_q + 16'h1;
      ref_clk_o <= rst_i ? 1'b0 : ref_clk_o ^ wrap;
   end
   // exactly one output goes back to the loop
   assign loop_return_o = ret_i[2] ? out_b_i[ret_i[1:0]] : out_a_i[ret_i[1:0]];
endmodule

// *** sim/psb_top_monitor.sv ***
// port checker of the skew clock buffer: bus answer and output relations
// assumes a bind into psb_top; sees only that module's ports
`timescale 1ns/100ps
module psb_top_monitor
   import psb_pkg::*;
(
   input wire logic        clk_i,              // clock
   input wire logic        rst_i,              // reset
   input wire logic        wb_cyc_i,           // cycle
   input wire logic        wb_stb_i,           // strobe
   input wire logic        wb_we_i,            // write
   input wire logic [7:0]  wb_adr_i,           // address
   input wire logic [3:0]  wb_sel_i,           // lanes
   input wire logic [31:0] wb_dat_i,           // write data
   input wire logic [31:0] wb_dat_o,           // read data
   input wire logic        wb_ack_o,           // answer
   input wire logic        ref_clk_i,          // reference
   input wire logic        loop_return_i,      // returned output
   input wire logic [3:0]  section_output_a_o, // first outputs
   input wire logic [3:0]  section_output_b_o  // second outputs
);
   // ==========================================================================
   // select shadow and quiet time after each select write
   logic [15:0] sect_q;
   logic [2:0]  quiet_q;
   wire         take = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & (wb_adr_i == REG_SECT);
   wire         calm = &quiet_q;
   wire  [3:0]  qa   = section_output_a_o;
   function automatic logic [3:0] lv(input logic [3:0] s);  // code 11 reads as mid
      lv = {(s[3:2] == 2'h3) ? 2'h1 : s[3:2], (s[1:0] == 2'h3) ? 2'h1 : s[1:0]};
   endfunction
   wire  [3:0]  c0   = lv(sect_q[3:0]);
   wire  [3:0]  c1   = lv(sect_q[7:4]);
   wire  [3:0]  c2   = lv(sect_q[11:8]);
   wire  [3:0]  c3   = lv(sect_q[15:12]);
   always_ff @(posedge clk_i) begin
      if (rst_i || take) begin
         sect_q  <= rst_i ? 16'h5555 : wb_dat_i[15:0];
         quiet_q <= 3'h0;
      end else if (!calm) begin
         quiet_q <= quiet_q + 3'h1;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ==========================================================================
   // assertions
   a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack after request");
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   a_reset_clears: assert property (disable iff (1'b0) rst_i |=> qa == 4'h0 && !wb_ack_o && wb_dat_o == 32'h0)
      else $error("reset left outputs set");
   a_pair_identical: assert property (section_output_a_o == section_output_b_o)
      else $error("section outputs differ");
   a_same_code_same: assert property (calm && c0 == c1 |-> qa[0] == qa[1])
      else $error("equal codes differ");
   a_wide_zero_aligned: assert property (calm && c0 == 4'h5 && c2 == 4'h5 |-> qa[2] == qa[0])
      else $error("zero skew sections differ");
   a_inverted_zero: assert property (calm && c0 == 4'h5 && c3 == 4'ha |-> qa[3] != qa[0])
      else $error("inverted output not inverse");
   a_divided_falls: assert property (calm && c2 == 4'ha && c3 == 4'h0 && $fell(qa[2]) |-> $fell(qa[3]))
      else $error("divided outputs fall apart");
endmodule
bind psb_top psb_top_monitor u_mon (.*);

// *** sim/test_programmable_skew_clock_buffer.sv ***
// bench for the skew clock buffer: registers, lock, ranges, skews, divides, bypass
// assumes psb_top with SCALE 20 and the reference model on its clock pins
`timescale 1ns/100ps
module test_programmable_skew_clock_buffer
   import psb_pkg::*;
;
   localparam int SC = 20;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        we    = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [31:0] wdat  = 32'h0;
   logic [31:0] rdat;
   logic [15:0] half  = 16'h004b;  // 150 cycle reference
   logic [2:0]  rsel  = 3'h0;      // returned output
   wire  [31:0] dat_o;
   wire         ack;
   wire         refc;
   wire         ret;
   wire  [3:0]  qa;
   wire  [3:0]  qb;
   wire  [4:0]  sv = {qa, refc};
   int          mismatches = 0;
   int          num_checks = 0;
   int          rc[3] = '{0, 2, 3};
   int          fmn[3] = '{15, 25, 40};
   int          fmx[3] = '{30, 50, 80};
   int          nn[3] = '{44, 26, 16};
   always #2 clk_i = ~clk_i;
   psb_top #(.SCALE(SC), .PH_TOL(2), .LOCK_EDGES(4)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .ref_clk_i(refc),
      .loop_return_i(ret), .section_output_a_o(qa), .section_output_b_o(qb));
   psb_ref_model u_ref (.clk_i(clk_i), .rst_i(rst_i), .half_i(half), .ret_i(rsel), .out_a_i(qa),
      .out_b_i(qb), .ref_clk_o(refc), .loop_return_o(ret));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s exp %0h got %0h", n, e, g);
      end
   endtask
   task automatic near(string n, int e, int g, int tol, int m);  // distance modulo m
      int d;
      d = ((g - e) % m + m) % m;
      num_checks++;
      if (d > tol && m - d > tol) begin
         mismatches++;
         $display("[ERR] %s exp %0d got %0d", n, e, g);
      end
   endtask
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);  // one classic single cycle
      int i;
      @(posedge clk_i);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      for (i = 0; i < 50 && ack !== 1'b1; i++)
         @(posedge clk_i);
      rdat = dat_o;
      cyc  <= 1'b0;
      if (i >= 50) begin
         chk("ack", 32'h1, 32'h0);
         end_sim();
      end
   endtask
   task automatic poll(logic [7:0] a, logic [31:0] m, logic [31:0] e);  // read until field matches
      int i;
      for (i = 0; i < 800; i++) begin
         bus(1'b0, a, 32'h0);
         if ((rdat & m) === e)
            break;
         repeat (40) @(posedge clk_i);
      end
      chk("polled field", e, rdat & m);
      if ((rdat & m) !== e)
         end_sim();
   endtask
   task automatic gap(int f, int t, output int d);  // cycles from a rise of f to next rise of t
      logic [4:0] p;
      for (int i = 0; i < 2; i++) begin
         p = sv;
         for (d = 0; d < 3000 && !(sv[i ? t : f] && !p[i ? t : f]); d++) begin
            p = sv;
            @(posedge clk_i);
         end
         if (d >= 3000) begin
            near("edge", 0, d, 0, 100000);
            end_sim();
         end
      end
   endtask
   initial begin
      int g;
      int j;
      int p;
      logic [3:0] n;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, REG_CTRL, 32'h0);
      chk("ctrl", 32'h1, rdat);
      bus(1'b0, REG_SECT, 32'h0);
      chk("sect", 32'h5555, rdat);
      bus(1'b1, 8'h20, 32'hffff);
      bus(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, rdat);
      $display("test registers done");
      poll(REG_STATUS, 32'h1, 32'h1);
      poll(REG_TIMING, 32'hffffffff, {16'h5, 16'h96});
      bus(1'b0, REG_REFPER, 32'h0);
      chk("refper", 32'h96, rdat & 32'hffff);
      $display("test lock done");
      foreach (rc[i]) begin
         j = (rc[i] == 3) ? 1 : rc[i];
         p = 150;
         if (p < CLK_MHZ * SC / fmx[j])
            p = CLK_MHZ * SC / fmx[j];
         if (p > CLK_MHZ * SC / fmn[j])
            p = CLK_MHZ * SC / fmn[j];
         bus(1'b1, REG_CTRL, 32'(rc[i]));
         poll(REG_TIMING, 32'hffffffff, {16'(p / nn[j]), 16'(p)});
         bus(1'b0, REG_STATUS, 32'h0);
         chk("at limit", 32'(p != 150), {31'h0, rdat[1]});
      end
      $display("test ranges done");
      for (int k = 0; k < 9; k++) begin
         n = {2'(k / 3), 2'(k % 3)};
         bus(1'b1, REG_SECT, {16'h0, n, n, n, 4'h5});
         gap(1, 2, g);
         near("sect2 skew", (k - 4) * 5, g, 2, 150);
         if (k != 0 && k != 8) begin
            gap(1, 3, g);
            near("sect3 skew", (k - 4) * 10, g, 2, 150);
            gap(1, 4, g);
            near("sect4 skew", (k - 4) * 10, g, 2, 150);
         end
      end
      $display("test skews done");
      bus(1'b1, REG_SECT, 32'h0aff);
      gap(3, 3, g);
      near("div4 period", 600, g, 2, 100000);
      gap(4, 4, g);
      near("div2 period", 300, g, 2, 100000);
      bus(1'b1, REG_SECT, 32'ha555);
      gap(1, 4, g);
      near("inverted", 75, g, 2, 150);
      $display("test functions done");
      bus(1'b1, REG_SECT, 32'h5950);
      poll(REG_STATUS, 32'h1, 32'h0);
      poll(REG_STATUS, 32'h1, 32'h1);
      gap(0, 3, g);
      near("skewed return", 50, g, 3, 150);
      bus(1'b1, REG_SECT, 32'ha555);
      rsel <= 3'h3;
      poll(REG_STATUS, 32'h1, 32'h0);
      poll(REG_STATUS, 32'h1, 32'h1);
      gap(0, 4, g);
      near("inverted return", 0, g, 3, 150);
      gap(0, 1, g);
      near("zero skew inverted", 75, g, 3, 150);
      $display("test return done");
      half <= 16'h005a;
      for (int k = 1; k < 4; k++) begin
         bus(1'b1, REG_CTRL, 32'((k % 3) * 4 + 1));
         poll(REG_STATUS, 32'h4, (k < 3) ? 32'h4 : 32'h0);
         if (k < 3) begin
            poll(REG_TIMING, 32'hffff, 32'hb4);
            gap(0, 1, g);
            near("bypass zero", 0, g, 3, 180);
            gap(0, 4, g);
            near("bypass invert", 90, g, 3, 180);
         end
      end
      $display("test bypass done");
      end_sim();
   end
endmodule

// *** verilog/psb_edge_meter.sv ***
// rising edge detector and period meter for one sampled clock input
// assumes the input is synchronous to clk_i
`timescale 1ns/100ps
module psb_edge_meter #(
   parameter int W = 16
) (
   input  wire logic         clk_i,     // system clock
   input  wire logic         rst_i,     // synchronous reset, active high
   input  wire logic         level_i,   // sampled clock level
   output logic              edge_o,    // rising edge seen this cycle
   output logic [W-1:0]      period_o,  // cycles between the last two edges
   output logic [W-1:0]      since_o,   // cycles since last edge, minus one
   output logic              valid_o    // period holds a real measurement
);

   logic         lvl_q;
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic [W-1:0] per_q;
   logic [1:0]   seen_q;

   // ==========================================================================
   // edge and saturating counter
   assign edge_o   = level_i & ~lvl_q;
   assign cnt_d    = edge_o ? '0 : ((cnt_q == '1) ? cnt_q : cnt_q + 1'b1);
   assign period_o = per_q;
   assign since_o  = cnt_q;
   assign valid_o  = seen_q[1];

   // measurement registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lvl_q  <= 1'b0;
         cnt_q  <= '0;
         per_q  <= '0;
         seen_q <= 2'h0;
      end else begin
         lvl_q <= level_i;
         cnt_q <= cnt_d;
         if (edge_o) begin
            per_q  <= (cnt_q == '1) ? cnt_q : cnt_q + 1'b1;
            seen_q <= {seen_q[0], 1'b1};
         end
      end
   end

endmodule

// *** verilog/psb_pkg.sv ***
// shared constants, types and helpers of the programmable skew clock buffer model
// assumes a single 250 MHz system clock; all waveforms are counted in its cycles
package psb_pkg;

   // ==========================================================================
   // clock and time scale
   localparam int CLK_PERIOD_NS = 4;                        // system clock period
   localparam int CLK_MHZ       = 1000 / CLK_PERIOD_NS;     // system clock rate
   localparam int PER_W         = 16;                       // width of phase and period counters

   // ==========================================================================
   // three-level select encoding (open pin reads as mid)
   localparam logic [1:0] LVL_LOW  = 2'h0;
   localparam logic [1:0] LVL_MID  = 2'h1;
   localparam logic [1:0] LVL_HIGH = 2'h2;

   // ==========================================================================
   // time unit divisors per range select
   localparam logic [PER_W-1:0] N_LOW  = 16'h002c;          // 44
   localparam logic [PER_W-1:0] N_MID  = 16'h001a;          // 26
   localparam logic [PER_W-1:0] N_HIGH = 16'h0010;          // 16

   // nominal range limits in MHz per range select
   localparam int FMIN_LOW_MHZ  = 15;
   localparam int FMAX_LOW_MHZ  = 30;
   localparam int FMIN_MID_MHZ  = 25;
   localparam int FMAX_MID_MHZ  = 50;
   localparam int FMIN_HIGH_MHZ = 40;
   localparam int FMAX_HIGH_MHZ = 80;

   // ==========================================================================
   // register map (byte addresses, one word each)
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_SECT   = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_TIMING = 8'h0c;
   localparam logic [7:0] REG_REFPER = 8'h10;

   // status bit positions
   localparam int ST_LOCKED = 0;
   localparam int ST_LIMIT  = 1;
   localparam int ST_BYPASS = 2;

   // ==========================================================================
   // configuration carriers
   typedef struct packed {
      logic [1:0] high_sel;                                 // section_select_high
      logic [1:0] low_sel;                                  // section_select_low
   } psb_sel_s;

   typedef struct packed {
      logic [1:0] test_sel;                                 // loop bypass select
      logic [1:0] range_sel;                                // range_select
   } psb_ctrl_s;

   localparam psb_ctrl_s CTRL_RST = '{test_sel: LVL_LOW, range_sel: LVL_MID};
   localparam psb_sel_s  SEL_RST  = '{high_sel: LVL_MID, low_sel: LVL_MID};

   // output function of one section
   typedef enum logic [3:0] {
      FN_SKEW = 4'b0001,
      FN_DIV2 = 4'b0010,
      FN_DIV4 = 4'b0100,
      FN_INV  = 4'b1000
   } psb_func_e;

   // ==========================================================================
   // helpers
   // unused code 11 is treated like an open pin
   function automatic logic [1:0] psb_level(input logic [1:0] raw);
      psb_level = (raw == 2'h3) ? LVL_MID : raw;
   endfunction

   // skew step = oscillator period divided by N of the range
   function automatic logic [PER_W-1:0] psb_step(input logic [PER_W-1:0] per, input logic [1:0] fs);
      case (psb_level(fs))
         LVL_LOW:  psb_step = per / N_LOW;
         LVL_HIGH: psb_step = per / N_HIGH;
         default:  psb_step = per / N_MID;
      endcase
   endfunction

   // oscillator period limit in cycles; the model runs slower than the part by scale
   function automatic logic [PER_W-1:0] psb_per_lim(input logic [1:0] fs, input int scale, input logic want_max);
      int f;
      f = 0;
      case (psb_level(fs))
         LVL_LOW:  f = want_max ? FMIN_LOW_MHZ : FMAX_LOW_MHZ;
         LVL_HIGH: f = want_max ? FMIN_HIGH_MHZ : FMAX_HIGH_MHZ;
         default:  f = want_max ? FMIN_MID_MHZ : FMAX_MID_MHZ;
      endcase
      psb_per_lim = PER_W'((CLK_MHZ * scale) / f);
   endfunction

endpackage

// *** verilog/psb_section.sv ***
// one output section: two identical outputs built from the shared aligned phase
// assumes phase, period and step come from the loop in the same clock domain
`timescale 1ns/100ps
module psb_section
   import psb_pkg::*;
#(
   parameter bit WIDE = 1'b0,   // sections three and four: double steps, divide modes
   parameter bit INV  = 1'b0    // section four: top code inverts instead of div by 4
) (
   input  wire logic             clk_i,     // system clock
   input  wire logic             rst_i,     // synchronous reset, active high
   input  wire psb_sel_s         sel_i,     // raw select pair
   input  wire logic [PER_W-1:0] phase_i,   // aligned oscillator phase
   input  wire logic [PER_W-1:0] period_i,  // oscillator period
   input  wire logic [PER_W-1:0] step_i,    // skew step in cycles
   input  wire logic [1:0]       div_i,     // count of whole oscillator periods
   output logic                  out_a_o,   // section_output_a
   output logic                  out_b_o    // section_output_b
);

   logic [1:0]       hi;
   logic [1:0]       lo;
   logic signed [4:0] sk3;
   logic signed [4:0] sk;
   logic [3:0]       mag;
   logic [PER_W-1:0] off;
   logic [PER_W:0]   adv_sum;
   logic [PER_W-1:0] x_del;
   logic [PER_W-1:0] x_adv;
   logic [PER_W-1:0] x;
   psb_func_e        func;
   logic             wave;
   logic             a_q;
   logic             b_q;

   // ==========================================================================
   // select decode: code = 3*high + low - 4 steps
   assign hi   = psb_level(sel_i.high_sel);
   assign lo   = psb_level(sel_i.low_sel);
   assign sk3  = 5'(3 * {3'h0, hi}) + {3'h0, lo} - 5'sh04;
   assign sk   = WIDE ? 5'(sk3 * 5'sh02) : sk3;
   assign func = (WIDE && hi == LVL_LOW && lo == LVL_LOW) ? FN_DIV2 :
                 (WIDE && hi == LVL_HIGH && lo == LVL_HIGH) ? (INV ? FN_INV : FN_DIV4) :
                 FN_SKEW;

   // shifted phase: positive skew delays, negative advances
   assign mag     = sk[4] ? 4'(-sk) : sk[3:0];
   assign off     = PER_W'(mag * step_i);
   assign x_del   = (phase_i >= off) ? phase_i - off : phase_i + period_i - off;
   assign adv_sum = {1'b0, phase_i} + {1'b0, off};
   assign x_adv   = (adv_sum >= {1'b0, period_i}) ? PER_W'(adv_sum - {1'b0, period_i}) : adv_sum[PER_W-1:0];
   assign x       = sk[4] ? x_adv : x_del;

   // waveform per function, all from the same aligned phase
   assign wave = (func == FN_DIV2) ? div_i[0] :
                 (func == FN_DIV4) ? ~div_i[1] :
                 (func == FN_INV)  ? ~(phase_i < (period_i >> 1)) :
                 (x < (period_i >> 1));

   // both outputs of a pair behave identically
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         a_q <= 1'b0;
         b_q <= 1'b0;
      end else begin
         a_q <= wave;
         b_q <= wave;
      end
   end

   assign out_a_o = a_q;
   assign out_b_o = b_q;

endmodule

// *** verilog/psb_top.sv ***
// programmable skew clock buffer: digital loop, skew generator, four sections
// assumes a classic wishbone master and reference/feedback inputs synchronous to clk_i
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/100ps

module psb_top
   import psb_pkg::*;
#(
   parameter int SCALE      = 100,  // model runs this many times slower than the part
   parameter int PH_TOL     = 2,    // cycles of phase error still called aligned
   parameter int LOCK_EDGES = 16    // aligned reference edges before lock is shown
) (
   input  wire logic        clk_i,               // system clock
   input  wire logic        rst_i,               // synchronous reset, active high
   input  wire logic        wb_cyc_i,            // wishbone cycle
   input  wire logic        wb_stb_i,            // wishbone strobe
   input  wire logic        wb_we_i,             // wishbone write enable
   input  wire logic [7:0]  wb_adr_i,            // wishbone byte address
   input  wire logic [3:0]  wb_sel_i,            // wishbone byte enables
   input  wire logic [31:0] wb_dat_i,            // wishbone write data
   output logic [31:0]      wb_dat_o,            // wishbone read data
   output logic             wb_ack_o,            // wishbone acknowledge
   input  wire logic        ref_clk_i,           // reference clock input
   input  wire logic        loop_return_i,       // loop_return_input from one output
   output logic [3:0]       section_output_a_o,  // first output of each section
   output logic [3:0]       section_output_b_o   // second output of each section
);

   localparam logic [PER_W-1:0] PER_RST   = psb_per_lim(LVL_MID, SCALE, 1'b1);
   localparam logic [PER_W-1:0] PH_TOL_C  = PER_W'(PH_TOL);
   localparam logic [7:0]       LOCK_MAX  = 8'(LOCK_EDGES);
   localparam logic [1:0]       CORR_HOLD = 2'h2;   // returned edges until a clean period

   // ==========================================================================
   // register bus
   psb_ctrl_s        ctrl_q;
   psb_sel_s [3:0]   sect_q;
   logic             ack_q;
   logic [31:0]      dat_q;
   logic             bus_req;
   logic             wr_en;
   logic [31:0]      rd_mux;
   logic [31:0]      status_w;

   // ==========================================================================
   // loop state
   logic             ref_edge;
   logic [PER_W-1:0] ref_per;
   logic [PER_W-1:0] ref_since;
   logic             ref_valid;
   logic             fb_edge;
   logic [PER_W-1:0] fb_per;
   logic [PER_W-1:0] fb_since;
   logic             fb_valid;
   logic [PER_W-1:0] ph_q;
   logic [PER_W-1:0] ph_d;
   logic [PER_W-1:0] per_q;
   logic [PER_W-1:0] per_d;
   logic [1:0]       dv_q;
   logic [1:0]       corr_q;
   logic [7:0]       lock_cnt_q;
   logic             locked_q;
   logic             bypass;
   logic [PER_W-1:0] per_min;
   logic [PER_W-1:0] per_max;
   logic [PER_W-1:0] step;
   logic [PER_W-1:0] fb_lead;
   logic             aligned;
   logic             fb_early;
   logic             measure_ok;
   logic             do_slip;
   logic             do_adv;
   logic [PER_W-1:0] ph_step1;
   logic [PER_W-1:0] ph_step2;
   logic [PER_W-1:0] ph_norm;
   logic [PER_W-1:0] per_adj;
   logic [PER_W-1:0] per_clamp;
   logic             at_limit;

   // bus decode and read selection
   assign bus_req  = wb_cyc_i & wb_stb_i;
   assign wr_en    = bus_req & ack_q & wb_we_i;
   assign status_w = {29'h0, bypass, at_limit, locked_q};
   assign rd_mux   = (wb_adr_i == REG_CTRL)   ? {28'h0, ctrl_q} :
                     (wb_adr_i == REG_SECT)   ? {16'h0, sect_q} :
                     (wb_adr_i == REG_STATUS) ? status_w :
                     (wb_adr_i == REG_TIMING) ? {step, per_q} :
                     (wb_adr_i == REG_REFPER) ? {16'h0, ref_per} :
                     32'h0;

   // ack one cycle after the request, data latched with it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0;
      end else begin
         ack_q <= bus_req & ~ack_q;
         if (bus_req & ~ack_q) begin
            dat_q <= rd_mux;
         end
      end
   end

   // configuration writes take effect at the acknowledged edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= CTRL_RST;
         sect_q <= {4{SEL_RST}};
      end else if (wr_en) begin
         if (wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
            ctrl_q <= wb_dat_i[3:0];
         end
         if (wb_adr_i == REG_SECT && wb_sel_i[0]) begin
            sect_q[1:0] <= wb_dat_i[7:0];
         end
         if (wb_adr_i == REG_SECT && wb_sel_i[1]) begin
            sect_q[3:2] <= wb_dat_i[15:8];
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // ==========================================================================
   // phase and frequency detection
   psb_edge_meter #(.W(PER_W)) u_ref_meter (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .level_i  (ref_clk_i),
      .edge_o   (ref_edge),
      .period_o (ref_per),
      .since_o  (ref_since),
      .valid_o  (ref_valid)
   );

   psb_edge_meter #(.W(PER_W)) u_fb_meter (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .level_i  (loop_return_i),
      .edge_o   (fb_edge),
      .period_o (fb_per),
      .since_o  (fb_since),
      .valid_o  (fb_valid)
   );

   // rising edge alignment of reference and returned clock
   assign bypass     = (psb_level(ctrl_q.test_sel) != LVL_LOW);
   assign measure_ok = ref_edge & ref_valid & fb_valid & ~bypass;
   assign fb_lead    = fb_edge ? '0 : fb_since + 1'b1;
   assign aligned    = (fb_lead <= PH_TOL_C) || (fb_lead + PH_TOL_C >= ref_per);
   assign fb_early   = fb_lead < (ref_per >> 1);
   assign do_slip    = measure_ok & (fb_per == ref_per) & ~aligned & fb_early;
   assign do_adv     = measure_ok & (fb_per == ref_per) & ~aligned & ~fb_early;

   // ==========================================================================
   // oscillator: period tracking, clamped to the selected range; in bypass it takes the reference period unclamped
   assign per_min  = psb_per_lim(ctrl_q.range_sel, SCALE, 1'b0);
   assign per_max  = psb_per_lim(ctrl_q.range_sel, SCALE, 1'b1);
   assign per_adj  = (measure_ok & ~|corr_q & (fb_per > ref_per)) ? per_q - 1'b1 :
                     (measure_ok & ~|corr_q & (fb_per < ref_per)) ? per_q + 1'b1 :
                     per_q;
   assign per_clamp = (per_adj < per_min) ? per_min :
                      (per_adj > per_max) ? per_max : per_adj;
   assign per_d    = bypass ? ((ref_edge & ref_valid) ? ref_per : per_q) : per_clamp;
   assign at_limit = ~bypass & ((per_q == per_min) | (per_q == per_max));
   assign step     = psb_step(per_q, ctrl_q.range_sel);

   // phase counter: slip or double step to pull the returned edge onto the reference
   assign ph_step1 = (ph_q + 1'b1 >= per_q) ? '0 : ph_q + 1'b1;
   assign ph_step2 = (ph_q + 2'h2 >= per_q) ? ph_q + 2'h2 - per_q : ph_q + 2'h2;
   assign ph_norm  = do_slip ? ph_q : (do_adv ? ph_step2 : ph_step1);
   assign ph_d     = (bypass & ref_edge) ? '0 : ph_norm;

   // phase, period and divider state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ph_q  <= '0;
         per_q <= PER_RST;
         dv_q  <= 2'h0;
      end else begin
         ph_q  <= ph_d;
         per_q <= per_d;
         if (ph_d < ph_q) begin
            dv_q <= dv_q + 1'b1;
         end
      end
   end

   // a correction distorts the returned period it lands in; frequency waits for the clean one after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         corr_q <= 2'h0;
      end else if (do_slip | do_adv) begin
         corr_q <= CORR_HOLD;
      end else if (fb_edge & |corr_q) begin
         corr_q <= corr_q - 2'h1;
      end
   end

   // lock indication after a run of aligned reference edges
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_cnt_q <= 8'h0;
         locked_q   <= 1'b0;
      end else if (bypass) begin
         lock_cnt_q <= 8'h0;
         locked_q   <= 1'b0;
      end else if (measure_ok) begin
         if (aligned && fb_per == ref_per) begin
            lock_cnt_q <= (lock_cnt_q == LOCK_MAX) ? lock_cnt_q : lock_cnt_q + 1'b1;
            locked_q   <= (lock_cnt_q + 1'b1 >= LOCK_MAX);
         end else begin
            lock_cnt_q <= 8'h0;
            locked_q   <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // output sections; the returned one fixes the timing of all others
   for (genvar s = 0; s < 4; s++) begin : g_sect
      psb_section #(
         .WIDE (s >= 2),
         .INV  (s == 3)
      ) u_sect (
         .clk_i    (clk_i),
         .rst_i    (rst_i),
         .sel_i    (sect_q[s]),
         .phase_i  (ph_q),
         .period_i (per_q),
         .step_i   (step),
         .div_i    (dv_q),
         .out_a_o  (section_output_a_o[s]),
         .out_b_o  (section_output_b_o[s])
      );
   end

endmodule
